// >>> rtl/dmct_ctrl.sv
// Host controller driving an asynchronous 32-bit multiplexed-address DRAM module
`timescale 1ns/1ps
module dmct_ctrl #(
    parameter int GRADE            = 0,
    parameter int INIT_WAIT_CYC    = dmct_pkg::cyc_min(longint'(dmct_pkg::INIT_PAUSE_NS)),
    parameter int PAGE_MAX_CYC     = dmct_pkg::cyc_max(longint'(dmct_pkg::PAGE_ROW_MAX_NS) * 1000),
    parameter int REF_INTERVAL_CYC = dmct_pkg::cyc_max(longint'(dmct_pkg::REFRESH_MS) * 64'd1000000000
                                                       / dmct_pkg::REFRESH_ROWS)
) (
    // Clock and reset
    input  wire logic                               sys_clk_i,
    input  wire logic                               rst_i,
    // User request port
    input  wire logic                               req_valid_i,
    input  wire dmct_pkg::dmct_req_t                req_i,
    output logic                                    req_ready_o,
    output logic                                    rd_valid_o,
    output logic [dmct_pkg::DATA_W-1:0]             rd_data_o,
    output logic                                    init_done_o,
    // Memory module pins
    output logic                                    ras_n_o,
    output logic [dmct_pkg::STROBE_W-1:0]           cas_n_o,
    output logic                                    we_n_o,
    output logic [dmct_pkg::ADDR_W-1:0]             multiplexed_address_o,
    input  wire logic [dmct_pkg::DATA_W-1:0]        data_lines_i,
    output logic [dmct_pkg::DATA_W-1:0]             data_lines_o,
    output logic                                    data_lines_oe_o
);

    localparam int G = GRADE;

    localparam logic [15:0] L_RC   = 16'(dmct_pkg::cyc_min(dmct_pkg::T_RC_NS[G]));
    localparam logic [15:0] L_RAS  = 16'(dmct_pkg::cyc_min(dmct_pkg::T_RAS_NS[G]));
    localparam logic [15:0] L_RP   = 16'(dmct_pkg::imax(dmct_pkg::cyc_min(dmct_pkg::T_RP_NS[G]),
                                                        dmct_pkg::cyc_min(dmct_pkg::T_RPC_NS)));
    localparam int          I_RAD  = dmct_pkg::cyc_min(dmct_pkg::T_RAD_NS[G]);
    localparam logic [15:0] L_RAD  = 16'(I_RAD);
    localparam logic [15:0] L_COLW = 16'(dmct_pkg::imax(1, dmct_pkg::cyc_min(dmct_pkg::T_RCD_NS[G]) - I_RAD));
    // Read length covers the slowest of the access paths plus the pin synchroniser
    localparam int          I_ACC  = dmct_pkg::imax(
                                         dmct_pkg::imax(dmct_pkg::cyc_min(dmct_pkg::T_CAC_NS[G]),
                                                        dmct_pkg::cyc_min(dmct_pkg::T_AA_NS[G])),
                                         dmct_pkg::imax(dmct_pkg::cyc_min(dmct_pkg::T_RAC_NS[G]),
                                                        dmct_pkg::cyc_min(dmct_pkg::T_CPA_NS[G])));
    localparam logic [15:0] L_RD   = 16'(I_ACC + dmct_pkg::SYNC_STAGES);
    localparam logic [15:0] L_WR   = 16'(dmct_pkg::imax(
                                         dmct_pkg::imax(dmct_pkg::cyc_min(dmct_pkg::T_CAS_NS[G]),
                                                        dmct_pkg::cyc_min(dmct_pkg::T_CWL_NS[G])),
                                         dmct_pkg::cyc_min(dmct_pkg::T_DH_NS[G])));
    localparam logic [15:0] L_CASHI = 16'(dmct_pkg::imax(
                                         dmct_pkg::imax(dmct_pkg::cyc_min(dmct_pkg::T_CP_NS),
                                                        dmct_pkg::cyc_min(dmct_pkg::T_OFF_NS[G])),
                                         dmct_pkg::cyc_min(dmct_pkg::T_PC_NS[G])));
    localparam logic [15:0] L_RHCP = 16'(dmct_pkg::cyc_min(dmct_pkg::T_RHCP_NS[G]));
    localparam logic [15:0] L_CSR  = 16'(dmct_pkg::cyc_min(dmct_pkg::T_CSR_NS));
    localparam logic [15:0] L_CHR  = 16'(dmct_pkg::cyc_min(dmct_pkg::T_CHR_NS));
    localparam logic [15:0] L_INIT = 16'(INIT_WAIT_CYC);
    localparam logic [15:0] L_INIT_HI = 16'(dmct_pkg::imax(dmct_pkg::cyc_min(dmct_pkg::T_RP_NS[G]),
                                         dmct_pkg::cyc_min(dmct_pkg::T_RC_NS[G])
                                         - dmct_pkg::cyc_min(dmct_pkg::T_RAS_NS[G])));
    // Worst-case length of one more page cycle, kept clear of the row pulse limit
    localparam logic [15:0] L_PAGE_LIM = 16'(PAGE_MAX_CYC - int'(L_RD) - int'(L_CASHI) - int'(L_RHCP) - 6);
    localparam logic [15:0] L_REF_INT  = 16'(REF_INTERVAL_CYC - 1);
    localparam logic [3:0]  L_INIT_N   = 4'(dmct_pkg::INIT_RAS_CYCLES - 1);
    localparam logic [15:0] L_ONE      = 16'h0001;

    dmct_pkg::dmct_state_t state_reg, state_next;
    logic [15:0]                    cnt_reg, cnt_next;
    logic [15:0]                    ras_time_reg;
    logic [15:0]                    hi_cnt_reg;
    logic [15:0]                    ref_timer_reg;
    logic                           ref_pend_reg;
    logic [3:0]                     init_cnt_reg;
    logic                           pend_reg, pend_next;
    dmct_pkg::dmct_req_t            req_reg;
    logic [dmct_pkg::ADDR_W-1:0]    open_row_reg;
    logic                           ext_reg;
    logic [dmct_pkg::DATA_W-1:0]    dq_s1_reg, dq_s2_reg, dq_s3_reg;
    logic                           ras_n_next;
    logic [dmct_pkg::STROBE_W-1:0]  cas_n_next;
    logic                           we_n_next;
    logic [dmct_pkg::ADDR_W-1:0]    addr_next;
    logic                           accept;
    logic                           done;
    logic                           agree;
    logic                           wr_phase;

    assign accept = req_valid_i && req_ready_o;
    assign done   = (cnt_reg == 16'h0000);
    assign agree  = (dq_s2_reg == dq_s3_reg);

    // Next state and countdown
    always_comb begin
        state_next = state_reg;
        cnt_next   = done ? 16'h0000 : cnt_reg - L_ONE;
        unique case (state_reg)
            dmct_pkg::DMCT_INIT_WAIT: begin
                if (done) begin
                    state_next = dmct_pkg::DMCT_INIT_LOW;
                    cnt_next   = L_RAS - L_ONE;
                end
            end
            dmct_pkg::DMCT_INIT_LOW: begin
                if (done) begin
                    state_next = dmct_pkg::DMCT_INIT_HIGH;
                    cnt_next   = L_INIT_HI - L_ONE;
                end
            end
            dmct_pkg::DMCT_INIT_HIGH: begin
                if (done) begin
                    if (init_cnt_reg == L_INIT_N) begin
                        state_next = dmct_pkg::DMCT_IDLE;
                    end else begin
                        state_next = dmct_pkg::DMCT_INIT_LOW;
                        cnt_next   = L_RAS - L_ONE;
                    end
                end
            end
            dmct_pkg::DMCT_IDLE: begin
                // Refresh ahead of user traffic so the row deadline is never missed
                if (ref_pend_reg) begin
                    // Entered only after a full precharge, so column strobe high time is never short
                    state_next = dmct_pkg::DMCT_REF_SETUP;
                    cnt_next   = L_CSR - L_ONE;
                end else if (pend_reg) begin
                    state_next = dmct_pkg::DMCT_ROW_OPEN;
                    cnt_next   = L_RAD - L_ONE;
                end
            end
            dmct_pkg::DMCT_ROW_OPEN: begin
                if (done) begin
                    state_next = dmct_pkg::DMCT_COL_SET;
                    cnt_next   = L_COLW - L_ONE;
                end
            end
            dmct_pkg::DMCT_COL_SET: begin
                if (done) begin
                    state_next = dmct_pkg::DMCT_CAS_LOW;
                    cnt_next   = (req_reg.write ? L_WR : L_RD) - L_ONE;
                end
            end
            dmct_pkg::DMCT_CAS_LOW: begin
                if (done && (req_reg.write || agree || ext_reg)) begin
                    state_next = dmct_pkg::DMCT_PAGE;
                    cnt_next   = L_CASHI - L_ONE;
                end
            end
            dmct_pkg::DMCT_PAGE: begin
                if (done) begin
                    if (pend_reg && req_reg.row == open_row_reg && ras_time_reg < L_PAGE_LIM) begin
                        state_next = dmct_pkg::DMCT_COL_SET;
                        cnt_next   = 16'h0000;
                    end else if (pend_reg || ref_pend_reg || ras_time_reg >= L_PAGE_LIM) begin
                        state_next = dmct_pkg::DMCT_RAS_CLOSE;
                    end
                end
            end
            dmct_pkg::DMCT_RAS_CLOSE: begin
                if (hi_cnt_reg >= L_RHCP && ras_time_reg >= L_RAS) begin
                    state_next = dmct_pkg::DMCT_PRECH;
                    cnt_next   = L_RP - L_ONE;
                end
            end
            dmct_pkg::DMCT_PRECH: begin
                if (done && ras_time_reg >= L_RC) begin
                    state_next = dmct_pkg::DMCT_IDLE;
                end
            end
            dmct_pkg::DMCT_REF_SETUP: begin
                if (done) begin
                    state_next = dmct_pkg::DMCT_REF_LOW;
                end
            end
            dmct_pkg::DMCT_REF_LOW: begin
                if (ras_time_reg >= L_RAS) begin
                    state_next = dmct_pkg::DMCT_PRECH;
                    cnt_next   = L_RP - L_ONE;
                end
            end
            default: begin
                state_next = dmct_pkg::DMCT_IDLE;
            end
        endcase
    end

    // Pending request slot and ready
    always_comb begin
        pend_next = pend_reg;
        if (state_reg == dmct_pkg::DMCT_CAS_LOW && state_next == dmct_pkg::DMCT_PAGE) begin
            pend_next = 1'b0;
        end
        if (accept) begin
            pend_next = 1'b1;
        end
    end

    // Pin values for the coming cycle
    always_comb begin
        wr_phase   = pend_reg && req_reg.write &&
                     (state_next == dmct_pkg::DMCT_COL_SET || state_next == dmct_pkg::DMCT_CAS_LOW);
        ras_n_next = !(state_next inside {dmct_pkg::DMCT_INIT_LOW, dmct_pkg::DMCT_ROW_OPEN,
                       dmct_pkg::DMCT_COL_SET, dmct_pkg::DMCT_CAS_LOW, dmct_pkg::DMCT_PAGE,
                       dmct_pkg::DMCT_RAS_CLOSE, dmct_pkg::DMCT_REF_LOW});
        cas_n_next = '1;
        if (state_next == dmct_pkg::DMCT_CAS_LOW) begin
            cas_n_next = req_reg.write ? ~req_reg.byte_en : '0;
        end else if (state_next == dmct_pkg::DMCT_REF_SETUP) begin
            cas_n_next = '0;
        end else if (state_next == dmct_pkg::DMCT_REF_LOW) begin
            // Column strobe released only once its hold after the row fall is met
            if (state_reg == dmct_pkg::DMCT_REF_SETUP || ras_time_reg < L_CHR) begin
                cas_n_next = '0;
            end
        end
        // Write select stays high outside write phases, so refresh never enters test mode
        we_n_next = !wr_phase;
        addr_next = multiplexed_address_o;
        if (state_next == dmct_pkg::DMCT_IDLE && pend_next) begin
            addr_next = accept ? req_i.row : req_reg.row;
        end else if (state_next == dmct_pkg::DMCT_COL_SET) begin
            addr_next = req_reg.col;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= dmct_pkg::DMCT_INIT_WAIT;
            cnt_reg   <= L_INIT - L_ONE;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            init_cnt_reg <= 4'h0;
            init_done_o  <= 1'b0;
        end else begin
            if (state_reg == dmct_pkg::DMCT_INIT_HIGH && state_next == dmct_pkg::DMCT_INIT_LOW) begin
                init_cnt_reg <= init_cnt_reg + 4'h1;
            end
            if (state_next == dmct_pkg::DMCT_IDLE) begin
                init_done_o <= 1'b1;
            end
        end
    end

    // Row strobe age: governs pulse width, cycle spacing and page limit
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ras_time_reg <= 16'h0000;
        end else if (ras_n_o && !ras_n_next) begin
            ras_time_reg <= 16'h0000;
        end else if (ras_time_reg != 16'hFFFF) begin
            ras_time_reg <= ras_time_reg + L_ONE;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hi_cnt_reg <= 16'h0000;
        end else if (state_reg == dmct_pkg::DMCT_CAS_LOW) begin
            hi_cnt_reg <= 16'h0000;
        end else if (hi_cnt_reg != 16'hFFFF) begin
            hi_cnt_reg <= hi_cnt_reg + L_ONE;
        end
    end

    // Distributed refresh: one row per interval, a request survives its own clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref_timer_reg <= L_REF_INT;
            ref_pend_reg  <= 1'b0;
        end else begin
            ref_timer_reg <= (ref_timer_reg == 16'h0000) ? L_REF_INT : ref_timer_reg - L_ONE;
            if (ref_timer_reg == 16'h0000) begin
                ref_pend_reg <= 1'b1;
            end else if (state_next == dmct_pkg::DMCT_REF_SETUP) begin
                ref_pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pend_reg     <= 1'b0;
            req_reg      <= '0;
            open_row_reg <= '0;
            req_ready_o  <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            if (accept) begin
                req_reg <= req_i;
            end
            if (state_next == dmct_pkg::DMCT_ROW_OPEN) begin
                open_row_reg <= req_reg.row;
            end
            req_ready_o <= !pend_next &&
                           (state_next == dmct_pkg::DMCT_IDLE || state_next == dmct_pkg::DMCT_PAGE);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ras_n_o               <= 1'b1;
            cas_n_o               <= '1;
            we_n_o                <= 1'b1;
            multiplexed_address_o <= '0;
            data_lines_o          <= '0;
            data_lines_oe_o       <= 1'b0;
        end else begin
            ras_n_o               <= ras_n_next;
            cas_n_o               <= cas_n_next;
            we_n_o                <= we_n_next;
            multiplexed_address_o <= addr_next;
            data_lines_o          <= req_reg.wdata;
            data_lines_oe_o       <= wr_phase;
        end
    end

    // Data line synchroniser: only the second and third stages are compared
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dq_s1_reg <= '0;
            dq_s2_reg <= '0;
            dq_s3_reg <= '0;
        end else begin
            dq_s1_reg <= data_lines_i;
            dq_s2_reg <= dq_s1_reg;
            dq_s3_reg <= dq_s2_reg;
        end
    end

    // Read capture at the end of the access window; one extra cycle if still settling
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ext_reg    <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o  <= '0;
        end else begin
            rd_valid_o <= 1'b0;
            ext_reg    <= state_reg == dmct_pkg::DMCT_CAS_LOW && done && !req_reg.write && !agree;
            if (state_reg == dmct_pkg::DMCT_CAS_LOW && state_next == dmct_pkg::DMCT_PAGE && !req_reg.write) begin
                rd_valid_o <= 1'b1;
                rd_data_o  <= dq_s3_reg;
            end
        end
    end

endmodule // dmct_ctrl

// >>> rtl/dmct_pkg.sv
// Constants, types and timing helpers for the DRAM module cycle controller
package dmct_pkg;

    localparam int ADDR_W   = 11;
    localparam int DATA_W   = 32;
    localparam int STROBE_W = 4;

    localparam int CLK_PS      = 5000;
    localparam int SYNC_STAGES = 3;

    localparam int INIT_PAUSE_NS   = 200000;
    localparam int INIT_RAS_CYCLES = 8;
    localparam int REFRESH_MS      = 32;
    localparam int REFRESH_ROWS    = 2048;
    localparam int PAGE_ROW_MAX_NS = 200000;

    // Per speed grade: index 0 fastest, 2 slowest; all in ns
    localparam int T_RC_NS   [3] = '{90, 110, 130};
    localparam int T_RAC_NS  [3] = '{50, 60, 70};
    localparam int T_CAC_NS  [3] = '{13, 15, 20};
    localparam int T_AA_NS   [3] = '{25, 30, 35};
    localparam int T_CPA_NS  [3] = '{30, 35, 40};
    localparam int T_OFF_NS  [3] = '{13, 15, 15};
    localparam int T_RP_NS   [3] = '{30, 40, 50};
    localparam int T_RAS_NS  [3] = '{50, 60, 70};
    localparam int T_CAS_NS  [3] = '{13, 15, 20};
    localparam int T_RCD_NS  [3] = '{17, 20, 20};
    localparam int T_RAD_NS  [3] = '{12, 15, 15};
    localparam int T_RHCP_NS [3] = '{30, 35, 40};
    localparam int T_PC_NS   [3] = '{35, 40, 45};
    localparam int T_CWL_NS  [3] = '{15, 15, 20};
    localparam int T_DH_NS   [3] = '{10, 10, 15};
    localparam int T_CP_NS   = 10;
    localparam int T_CSR_NS  = 5;
    localparam int T_CHR_NS  = 10;
    localparam int T_RPC_NS  = 5;

    typedef enum logic [3:0] {
        DMCT_INIT_WAIT, DMCT_INIT_LOW, DMCT_INIT_HIGH, DMCT_IDLE,
        DMCT_ROW_OPEN, DMCT_COL_SET, DMCT_CAS_LOW, DMCT_PAGE,
        DMCT_RAS_CLOSE, DMCT_PRECH, DMCT_REF_SETUP, DMCT_REF_LOW
    } dmct_state_t;

    typedef struct packed {
        logic                write;
        logic [ADDR_W-1:0]   row;
        logic [ADDR_W-1:0]   col;
        logic [DATA_W-1:0]   wdata;
        logic [STROBE_W-1:0] byte_en;
    } dmct_req_t;

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // Least time: round up, never below one cycle
    function automatic int cyc_min(input longint ns);
        longint c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : int'(c);
    endfunction

    // Longest time: round down, never below one cycle
    function automatic int cyc_max(input longint ps);
        longint c;
        c = ps / CLK_PS;
        return (c < 1) ? 1 : int'(c);
    endfunction

endpackage

// >>> test/dmct_ctrl_properties.sv
// Pin timing checks for the DRAM cycle controller, grade 0 figures
`timescale 1ns/1ps
module dmct_ctrl_props (
    // Clock and reset
    input wire logic                          sys_clk_i,
    input wire logic                          rst_i,
    // Memory pins
    input wire logic                          ras_n_o,
    input wire logic [dmct_pkg::STROBE_W-1:0] cas_n_o,
    input wire logic                          we_n_o,
    input wire logic [dmct_pkg::ADDR_W-1:0]   multiplexed_address_o,
    input wire logic [dmct_pkg::DATA_W-1:0]   data_lines_o,
    input wire logic                          data_lines_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic       cas_hi;
    logic [7:0] ras_gap, cfall_gap, crise_gap;
    assign cas_hi = &cas_n_o;
    // Saturating counts since the last strobe edges
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ras_gap   <= 8'hFF;
            cfall_gap <= 8'hFF;
            crise_gap <= 8'hFF;
        end else begin
            ras_gap   <= $fell(ras_n_o) ? 8'h01 : ras_gap + 8'(ras_gap != 8'hFF);
            cfall_gap <= $fell(cas_hi) ? 8'h01 : cfall_gap + 8'(cfall_gap != 8'hFF);
            crise_gap <= $rose(cas_hi) ? 8'h01 : crise_gap + 8'(crise_gap != 8'hFF);
        end
    end
    sequence wr_data_held;
        (data_lines_oe_o && $stable(data_lines_o))[*3];
    endsequence
    sequence rd_select_held;
        (we_n_o && !data_lines_oe_o)[*8];
    endsequence
    row_col_delay_a: assert property ($fell(ras_n_o) && cas_hi |-> cas_hi[*4])
        else $error("column strobe too soon after row strobe");
    address_hold_a: assert property ($fell(ras_n_o) && cas_hi |-> $stable(multiplexed_address_o)[*3])
        else $error("column address too soon after row strobe");
    cycle_spacing_a: assert property ($fell(ras_n_o) |-> ras_gap >= 8'd18)
        else $error("row cycles too close");
    page_cycle_a: assert property ($fell(cas_hi) |-> cfall_gap >= 8'd7)
        else $error("column cycles too close");
    cas_precharge_a: assert property ($rose(cas_hi) |-> cas_hi[*2])
        else $error("column precharge too short");
    row_hold_a: assert property ($rose(ras_n_o) |-> cas_hi && crise_gap >= 8'd6)
        else $error("row strobe rose too early");
    refresh_setup_a: assert property ($fell(ras_n_o) && !cas_hi |-> !$past(cas_hi) && !cas_hi ##1 !cas_hi)
        else $error("refresh column strobe timing");
    refresh_select_a: assert property ($fell(ras_n_o) && !cas_hi |-> $past(we_n_o) && $past(we_n_o, 2) && we_n_o ##1 we_n_o ##1 we_n_o)
        else $error("write select low around refresh");
    read_select_a: assert property ($fell(cas_hi) && we_n_o |-> rd_select_held)
        else $error("read select not held");
    early_write_a: assert property ($fell(cas_hi) && !we_n_o |-> !$past(we_n_o) ##0 wr_data_held)
        else $error("write data not held");
    write_lead_a: assert property ($rose(cas_hi) && !$past(we_n_o) |-> !$past(we_n_o, 3))
        else $error("write select lead too short");
endmodule // dmct_ctrl_props
bind dmct_ctrl dmct_ctrl_props dmct_ctrl_props_i (.sys_clk_i, .rst_i, .ras_n_o, .cas_n_o, .we_n_o,
    .multiplexed_address_o, .data_lines_o, .data_lines_oe_o);

// >>> test/dmct_mem_model.sv
// Behavioural memory module answering the controller strobes
`timescale 1ns/1ps
module dmct_mem_model (
    // Strobes and address
    input  wire logic                          ras_n_i,
    input  wire logic [dmct_pkg::STROBE_W-1:0] cas_n_i,
    input  wire logic                          we_n_i,
    input  wire logic [dmct_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic                          slow_i,
    // Data lines
    input  wire logic [dmct_pkg::DATA_W-1:0]   data_i,
    output logic [dmct_pkg::DATA_W-1:0]        data_o
);
    logic [31:0] mem [int];
    logic [10:0] row_q;
    realtime     t_ras, d;
    int          key;
    initial data_o = 32'h5A5AA5A5;
    always @(negedge ras_n_i) if (&cas_n_i) begin
        row_q = addr_i;
        t_ras = $realtime;
    end
    always @(negedge (&cas_n_i)) if (!ras_n_i) begin
        key = {row_q, addr_i};
        if (!we_n_i) begin
            if (!mem.exists(key)) mem[key] = '0;
            for (int i = 0; i < 4; i++) if (!cas_n_i[i]) mem[key][8*i +: 8] = data_i[8*i +: 8];
        end else begin
            // Slow answers arrive at the latest legal moment
            d = t_ras + 50.0 - $realtime;
            if (d < 13.0) d = 13.0;
            #(slow_i ? d : 1.0);
            data_o = mem.exists(key) ? mem[key] : '0;
        end
    end
    // Released lines float, shown as a changed value
    always @(posedge (&cas_n_i)) begin
        #(slow_i ? 13.0 : 1.0);
        data_o = ~data_o;
    end
endmodule // dmct_mem_model

// >>> test/test_dram_module_cycle_timing.sv
// Self-checking bench for the DRAM cycle controller
`timescale 1ns/1ps
module test_dram_module_cycle_timing;
    logic                sys_clk_i, rst_i, req_valid_i, slow;
    dmct_pkg::dmct_req_t req_i;
    logic                req_ready_o, rd_valid_o, init_done_o, ras_n_o, we_n_o, data_lines_oe_o;
    logic [3:0]          cas_n_o;
    logic [10:0]         multiplexed_address_o;
    logic [31:0]         rd_data_o, data_lines_o, mem_q, dq;
    int                  n_errors = 0, comparisons = 0, n_ras, n_ref;
    assign dq = data_lines_oe_o ? data_lines_o : mem_q;
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            n_ras <= 0;
            n_ref <= 0;
        end else if ($fell(ras_n_o)) begin
            n_ras <= n_ras + 1;
            n_ref <= n_ref + int'(cas_n_o == 4'h0);
        end
    end
    dmct_ctrl #(.INIT_WAIT_CYC(20), .PAGE_MAX_CYC(200), .REF_INTERVAL_CYC(300)) dmct_ctrl_i (.sys_clk_i, .rst_i,
        .req_valid_i, .req_i, .req_ready_o, .rd_valid_o, .rd_data_o, .init_done_o, .ras_n_o, .cas_n_o, .we_n_o,
        .multiplexed_address_o, .data_lines_i(dq), .data_lines_o, .data_lines_oe_o);
    dmct_mem_model dmct_mem_model_i (.ras_n_i(ras_n_o), .cas_n_i(cas_n_o), .we_n_i(we_n_o),
        .addr_i(multiplexed_address_o), .slow_i(slow), .data_i(dq), .data_o(mem_q));
    task automatic conclude;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded wait: 0 for ready, 1 for read data
    task automatic await(input int sel);
        for (int i = 0; i < 2000; i++) begin
            if ((sel == 0 && req_ready_o === 1'b1) || (sel == 1 && rd_valid_o === 1'b1)) return;
            @(negedge sys_clk_i);
        end
        n_errors++;
        $display("BAD %0t wait ran out", $time);
        conclude();
    endtask
    task automatic xfer(input logic wr, input int row, input int col, input logic [31:0] d, input logic [3:0] be);
        req_i = '{write: wr, row: 11'(row), col: 11'(col), wdata: d, byte_en: be};
        req_valid_i = 1'b1;
        await(0);
        @(negedge sys_clk_i);
        req_valid_i = 1'b0;
        // Ready falls on the same edge as the take
        @(negedge sys_clk_i);
    endtask
    task automatic rd(input int row, input int col, input logic [31:0] exp);
        xfer(1'b0, row, col, 32'h0, 4'hF);
        await(1);
        chk(rd_data_o, exp);
    endtask
    task automatic t_init;
        await(0);
        chk(n_ras, 32'd8);
        chk(init_done_o, 32'h1);
        $display("init finished");
    endtask
    task automatic t_page;
        xfer(1'b1, 5, 3, 32'hA1B2C3D4, 4'hF);
        xfer(1'b1, 5, 4, 32'h0F1E2D3C, 4'hF);
        rd(5, 3, 32'hA1B2C3D4);
        xfer(1'b1, 5, 3, 32'h11223344, 4'h5);
        rd(5, 3, 32'hA122C344);
        xfer(1'b1, 5, 4, 32'hFFFFFFFF, 4'h0);
        rd(5, 4, 32'h0F1E2D3C);
        $display("page mode finished");
    endtask
    task automatic t_miss;
        xfer(1'b1, 9, 1, 32'h600DCAFE, 4'hF);
        rd(5, 3, 32'hA122C344);
        slow = 1'b1;
        rd(9, 1, 32'h600DCAFE);
        rd(9, 1, 32'h600DCAFE);
        slow = 1'b0;
        $display("row change finished");
    endtask
    task automatic t_refresh;
        int n0;
        n0 = n_ref;
        repeat (700) @(negedge sys_clk_i);
        // Two interval expiries fall inside any 700-cycle idle window
        chk(32'((n_ref - n0) >= 2), 32'h1);
        rd(9, 1, 32'h600DCAFE);
        $display("refresh finished");
    endtask
    task automatic t_reset;
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        chk(ras_n_o, 32'h1);
        chk(req_ready_o, 32'h0);
        rst_i = 1'b0;
        t_init();
        rd(5, 4, 32'h0F1E2D3C);
        $display("reset finished");
    endtask
    initial begin
        rst_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        slow = 1'b0;
        repeat (12) @(negedge sys_clk_i);
        rst_i = 1'b0;
        t_init();
        t_page();
        t_miss();
        t_refresh();
        t_reset();
        conclude();
    end
endmodule // test_dram_module_cycle_timing
